//--- core/hsd_pkg.sv
// shared constants, field layout and config carrier for the high-side diag channel
// assumes a 125 MHz system clock and 16-bit registers in the low half of a 32-bit word
package hsd_pkg;
    // clock rate; every documented time is a count of this period
    localparam int unsigned CLK_FREQ_MHZ = 125;
    localparam int unsigned CLK_PERIOD_PS = 1000000 / CLK_FREQ_MHZ;
    // extra periods added to each programmed count
    localparam logic [7:0] BLANK_EXTRA = 8'h04;
    localparam logic [5:0] FILT_EXTRA = 6'h01;
    localparam logic [5:0] DEAD_EXTRA = 6'h01;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_FILTER_CFG = 10'h1D8;
    localparam logic [9:0] IDX_TABLE_CFG = 10'h1D9;
    localparam logic [9:0] IDX_ROUTING_CFG = 10'h1DA;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h101;
    localparam logic [9:0] IDX_CTRL = 10'h102;
    localparam logic [9:0] IDX_STATE = 10'h103;
    localparam int unsigned ADDR_W = 12;
    // filter config fields
    localparam int unsigned FILT_TYPE_BIT = 13;
    localparam int unsigned FILT_LEN_LSB = 7;
    localparam int unsigned WIN_LSB = 0;
    // table config fields
    localparam int unsigned TBL_SRC_LSB = 4;
    localparam int unsigned TBL_VDS_LSB = 0;
    // routing config fields
    localparam int unsigned BYPASS_BIT = 15;
    localparam int unsigned DEAD_LSB = 6;
    localparam int unsigned ROUTE_LSB = 1;
    localparam int unsigned INV_BIT = 0;
    // reset values
    localparam logic [15:0] FILTER_CFG_RST = 16'h0000;
    localparam logic [15:0] TABLE_CFG_RST = 16'h0000;
    localparam logic [15:0] ROUTING_CFG_RST = 16'h003E;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    // own control, status and interrupt bits
    localparam int unsigned CTRL_FW_EN = 0;
    localparam int unsigned IRQ_VDS = 0;
    localparam int unsigned IRQ_SRC = 1;
    // decoded configuration carried between processes
    typedef struct packed {
        logic filter_type;
        logic [5:0] filter_len;
        logic [6:0] window;
        logic [3:0] tbl_src;
        logic [3:0] tbl_vds;
        logic enable_bypass;
        logic [4:0] dead_time;
        logic [4:0] routing;
        logic inv;
    } hsd_cfg_s;
    // captured command and feedback at an error
    typedef struct packed {
        logic cmd;
        logic source;
        logic drain;
    } hsd_snap_s;
endpackage

//--- core/hsd_fb_filter.sv
// feedback glitch filter with programmable span and counting mode
// assumes the sample is synchronous to i_clk
`timescale 1ns/1ps
module hsd_fb_filter (
    input wire logic i_clk, // system clock
    input wire logic i_nrst, // async reset, low
    input wire logic i_sample, // raw feedback
    input wire logic [5:0] i_len, // span minus one
    input wire logic i_type, // 0 clear, 1 decrement
    output logic o_state // filtered feedback
);
    logic [5:0] cnt;

    // count differing samples, switch after len+1 of them
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 6'h00;
            o_state <= 1'b0;
        end else if (i_sample != o_state) begin
            if (cnt >= i_len) begin
                o_state <= i_sample;
                cnt <= 6'h00;
            end else begin
                cnt <= cnt + 6'h01;
            end
        end else if (i_type && cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
        end else begin
            cnt <= 6'h00;
        end
    end

    // assertions
    property p_filt_clear;
        @(posedge i_clk) disable iff (!i_nrst) (!i_type && i_sample == o_state) |=> cnt == 6'h00;
    endproperty
    a_filt_clear: assert property (p_filt_clear) else $error("filter count not cleared");
    property p_filt_dec;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_type && i_sample == o_state && cnt != 6'h00) |=> cnt == $past(cnt) - 6'h01;
    endproperty
    a_filt_dec: assert property (p_filt_dec) else $error("filter count not decremented");
    property p_filt_span;
        @(posedge i_clk) disable iff (!i_nrst) $changed(o_state) |-> $past(cnt) >= $past(i_len);
    endproperty
    a_filt_span: assert property (p_filt_span) else $error("filter switched early");
endmodule

//--- core/hsd_dead_time.sv
// dead-time generator: delays high-side rise and raises freewheel after fall
// assumes the command is synchronous to i_clk
`timescale 1ns/1ps
module hsd_dead_time (
    input wire logic i_clk, // system clock
    input wire logic i_nrst, // async reset, low
    input wire logic i_cmd, // high-side command
    input wire logic [4:0] i_dead, // dead-time count
    input wire logic i_fw_en, // freewheel mode on
    output logic o_hs, // delayed high-side command
    output logic o_fw // freewheel command
);
    logic cmd_q;
    logic [4:0] cnt;
    logic pending;

    // an edge is still waiting for its delayed output
    assign pending = cmd_q ? !o_hs : !o_fw;

    // edge tracking and delayed outputs
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_q <= 1'b0;
            cnt <= 5'h00;
            o_hs <= 1'b0;
            o_fw <= 1'b0;
        end else begin
            cmd_q <= i_cmd;
            if (!i_fw_en) begin
                o_hs <= i_cmd;
                o_fw <= 1'b0;
                cnt <= 5'h00;
            end else if (i_cmd != cmd_q) begin
                cnt <= 5'h00;
                if (i_cmd) begin
                    o_fw <= 1'b0;
                end else begin
                    o_hs <= 1'b0;
                end
            end else if (pending) begin
                if (cnt == i_dead) begin
                    cnt <= 5'h00;
                    if (cmd_q) begin
                        o_hs <= 1'b1;
                    end else begin
                        o_fw <= 1'b1;
                    end
                end else begin
                    cnt <= cnt + 5'h01;
                end
            end
        end
    end

    // assertions
    property p_fw_delay;
        @(posedge i_clk) disable iff (!i_nrst) ($rose(o_fw) && $past(i_fw_en)) |-> $past(cnt) == $past(i_dead);
    endproperty
    a_fw_delay: assert property (p_fw_delay) else $error("freewheel rose before dead time");
    property p_hs_delay;
        @(posedge i_clk) disable iff (!i_nrst) ($rose(o_hs) && $past(i_fw_en)) |-> $past(cnt) == $past(i_dead);
    endproperty
    a_hs_delay: assert property (p_hs_delay) else $error("high-side rose before dead time");
    property p_no_overlap;
        @(posedge i_clk) disable iff (!i_nrst) !(o_hs && o_fw);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("high-side and freewheel overlap");
endmodule

//--- core/hsd_channel.sv
// high-side output channel: routing, polarity, dead time, feedback diagnostics
// assumes Avalon-MM slave access, synchronous pins and a microcore that enables diagnostics
//
// Function
// - filter type picks counter clear or decrement
// - feedback filter lasts length field plus one clocks
// - blank both checks window plus four clocks
// - drain table indexed by command and feedback
// - source table uses same indexing
// - table hit signals error to microcore
// - freewheel rises dead time after fall
// - freewheel mode delays high-side rising edge
// - selectors 0-15 OR flag with microcore
// - selectors 16-31 use microcores only
// - invert flips the microcore command
// - invert does not alter table lookup
// - invert never applies to flag path
// - bypass bit ignores driver enable pin
// - bypass writable on channels five, seven only
// - latch command and feedback on error
`timescale 1ns/1ps
module hsd_channel #(
    parameter int unsigned CHANNEL = 1 // high-side channel number, 1..7
) (
    input wire logic i_clk, // system clock
    input wire logic i_nrst, // async reset, low
    input wire logic [11:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read strobe
    input wire logic i_avs_write, // write strobe
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic i_mc_cmd, // microcore command
    input wire logic i_mc_diag_en, // diagnostics enabled by microcore
    input wire logic [15:0] i_flags, // external flag inputs
    input wire logic i_drv_en, // driver enable pin
    input wire logic i_hs_drain_feedback, // drain voltage feedback
    input wire logic i_hs_source_feedback, // source voltage feedback
    output logic o_hs_drive, // pre-driver command
    output logic o_freewheel_command, // freewheel command
    output logic o_mc_error, // error to microcore
    output logic [2:0] o_err_snapshot, // latched cmd, source, drain
    output logic o_irq // interrupt, high
);
    // bypass exists only on two channels
    localparam logic BYPASS_OK = (CHANNEL == 5) || (CHANNEL == 7);

    // registers
    logic [15:0] filter_cfg;
    logic [15:0] table_cfg;
    logic [15:0] routing_cfg;
    logic [15:0] ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    hsd_pkg::hsd_cfg_s cfg;
    hsd_pkg::hsd_snap_s snap;
    // bus
    logic req;
    logic ack;
    logic wr_fire;
    logic [9:0] idx;
    logic [15:0] wmask;
    logic [15:0] next_rdata;
    // command path
    logic flag_sel;
    logic flag_bit;
    logic mc_drive;
    logic pre_cmd;
    logic diag_cmd;
    logic diag_cmd_q;
    logic hs_cmd;
    logic fw_cmd;
    // diagnostics
    logic vds_filt;
    logic src_filt;
    logic [7:0] blank_cnt;
    logic check_ok;
    logic hit_vds;
    logic hit_src;
    logic err_vds;
    logic err_src;
    logic err_q;

    // field decode into the carrier
    always_comb begin
        cfg.filter_type = filter_cfg[hsd_pkg::FILT_TYPE_BIT];
        cfg.filter_len = filter_cfg[hsd_pkg::FILT_LEN_LSB +: 6];
        cfg.window = filter_cfg[hsd_pkg::WIN_LSB +: 7];
        cfg.tbl_src = table_cfg[hsd_pkg::TBL_SRC_LSB +: 4];
        cfg.tbl_vds = table_cfg[hsd_pkg::TBL_VDS_LSB +: 4];
        cfg.enable_bypass = routing_cfg[hsd_pkg::BYPASS_BIT];
        cfg.dead_time = routing_cfg[hsd_pkg::DEAD_LSB +: 5];
        cfg.routing = routing_cfg[hsd_pkg::ROUTE_LSB +: 5];
        cfg.inv = routing_cfg[hsd_pkg::INV_BIT];
    end

    // bus decode: one wait cycle, then the access completes
    assign req = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = req && !ack;
    assign wr_fire = i_avs_write && ack;
    assign idx = i_avs_address[11:2];
    assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // acknowledge toggles once per request
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    // read multiplexer, unmapped reads as zero
    always_comb begin
        case (idx)
            hsd_pkg::IDX_FILTER_CFG: next_rdata = filter_cfg;
            hsd_pkg::IDX_TABLE_CFG: next_rdata = table_cfg;
            hsd_pkg::IDX_ROUTING_CFG: next_rdata = routing_cfg;
            hsd_pkg::IDX_CTRL: next_rdata = ctrl;
            hsd_pkg::IDX_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
            hsd_pkg::IDX_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
            hsd_pkg::IDX_STATE: next_rdata = {8'h00, hs_cmd, fw_cmd, o_mc_error, vds_filt, src_filt,
                                             snap.cmd, snap.source, snap.drain};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data loaded in the wait cycle, stands at the completing edge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && !ack) begin
            o_avs_readdata <= {16'h0000, next_rdata};
        end
    end

    // configuration writes, reserved bits kept at zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            filter_cfg <= hsd_pkg::FILTER_CFG_RST;
            table_cfg <= hsd_pkg::TABLE_CFG_RST;
            routing_cfg <= hsd_pkg::ROUTING_CFG_RST;
            ctrl <= hsd_pkg::CTRL_RST;
        end else if (wr_fire) begin
            case (idx)
                hsd_pkg::IDX_FILTER_CFG: filter_cfg <= (filter_cfg & ~wmask) | (i_avs_writedata[15:0] & wmask
                                                        & 16'h3FFF);
                hsd_pkg::IDX_TABLE_CFG: table_cfg <= (table_cfg & ~wmask) | (i_avs_writedata[15:0] & wmask
                                                      & 16'h00FF);
                hsd_pkg::IDX_ROUTING_CFG: routing_cfg <= (routing_cfg & ~wmask) | (i_avs_writedata[15:0] & wmask
                                                          & {BYPASS_OK, 15'h07FF});
                hsd_pkg::IDX_CTRL: ctrl <= (ctrl & ~wmask) | (i_avs_writedata[15:0] & wmask & 16'h0001);
                default: ctrl <= ctrl;
            endcase
        end
    end

    // interrupt mask register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_mask <= hsd_pkg::IRQ_MASK_RST;
        end else if (wr_fire && idx == hsd_pkg::IDX_IRQ_MASK && i_avs_byteenable[0]) begin
            irq_mask <= i_avs_writedata[1:0];
        end
    end

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status <= 2'h0;
        end else begin
            if (wr_fire && idx == hsd_pkg::IDX_IRQ_STATUS && i_avs_byteenable[0]) begin
                irq_status <= (irq_status & ~i_avs_writedata[1:0]) | {err_src, err_vds};
            end else begin
                irq_status <= irq_status | {err_src, err_vds};
            end
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // command source selection and polarity
    assign flag_sel = !cfg.routing[4];
    assign flag_bit = flag_sel && i_flags[cfg.routing[3:0]];
    assign mc_drive = i_mc_cmd ^ cfg.inv;
    assign pre_cmd = mc_drive || flag_bit;
    assign diag_cmd = i_mc_cmd || flag_bit;

    // dead time and freewheel generation
    hsd_dead_time u_dead (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_cmd(pre_cmd),
        .i_dead(cfg.dead_time),
        .i_fw_en(ctrl[hsd_pkg::CTRL_FW_EN]),
        .o_hs(hs_cmd),
        .o_fw(fw_cmd)
    );

    // driver enable gating, bypass only where it exists
    assign o_hs_drive = hs_cmd && (i_drv_en || (cfg.enable_bypass && BYPASS_OK));
    assign o_freewheel_command = fw_cmd;

    // feedback filters
    hsd_fb_filter u_filt_vds (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sample(i_hs_drain_feedback),
        .i_len(cfg.filter_len),
        .i_type(cfg.filter_type),
        .o_state(vds_filt)
    );
    hsd_fb_filter u_filt_src (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sample(i_hs_source_feedback),
        .i_len(cfg.filter_len),
        .i_type(cfg.filter_type),
        .o_state(src_filt)
    );

    // blanking after each command change
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            diag_cmd_q <= 1'b0;
            blank_cnt <= 8'h00;
        end else begin
            diag_cmd_q <= diag_cmd;
            if (diag_cmd != diag_cmd_q) begin
                blank_cnt <= {1'b0, cfg.window} + hsd_pkg::BLANK_EXTRA;
            end else if (blank_cnt != 8'h00) begin
                blank_cnt <= blank_cnt - 8'h01;
            end
        end
    end

    // table lookups on filtered feedback
    assign check_ok = i_mc_diag_en && blank_cnt == 8'h00 && diag_cmd == diag_cmd_q;
    assign hit_vds = cfg.tbl_vds[{diag_cmd_q, vds_filt}];
    assign hit_src = cfg.tbl_src[{diag_cmd_q, src_filt}];

    // error flags toward the microcore
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_vds <= 1'b0;
            err_src <= 1'b0;
            err_q <= 1'b0;
        end else begin
            err_vds <= check_ok && hit_vds;
            err_src <= check_ok && hit_src;
            err_q <= check_ok && (hit_vds || hit_src);
        end
    end

    assign o_mc_error = err_q;

    // snapshot of command and feedback at each new error
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            snap <= 3'h0;
        end else if (check_ok && (hit_vds || hit_src) && !err_q) begin
            snap <= {diag_cmd_q, src_filt, vds_filt};
        end
    end

    assign o_err_snapshot = snap;

    // assertions
    property p_blank;
        @(posedge i_clk) disable iff (!i_nrst) (diag_cmd != diag_cmd_q) |=> !check_ok [*4];
    endproperty
    a_blank: assert property (p_blank) else $error("check ran inside blanking");

    property p_blank_len;
        @(posedge i_clk) disable iff (!i_nrst)
            (diag_cmd != diag_cmd_q) |=> blank_cnt == {1'b0, $past(cfg.window)} + 8'h04;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blanking length wrong");

    property p_vds;
        @(posedge i_clk) disable iff (!i_nrst)
            (check_ok && cfg.tbl_vds[{diag_cmd_q, vds_filt}]) |=> err_vds && o_mc_error;
    endproperty
    a_vds: assert property (p_vds) else $error("drain table hit missed");

    property p_src;
        @(posedge i_clk) disable iff (!i_nrst)
            (check_ok && cfg.tbl_src[{diag_cmd_q, src_filt}]) |=> err_src && o_mc_error;
    endproperty
    a_src: assert property (p_src) else $error("source table hit missed");

    property p_err_cause;
        @(posedge i_clk) disable iff (!i_nrst) o_mc_error |-> $past(check_ok) && $past(hit_vds || hit_src);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error without table hit");

    property p_diag_gate;
        @(posedge i_clk) disable iff (!i_nrst) !i_mc_diag_en |=> !o_mc_error;
    endproperty
    a_diag_gate: assert property (p_diag_gate) else $error("error while diagnostics off");

    property p_mc_only;
        @(posedge i_clk) disable iff (!i_nrst)
            (cfg.routing[4] && !ctrl[hsd_pkg::CTRL_FW_EN]) |=> hs_cmd == $past(i_mc_cmd ^ cfg.inv);
    endproperty
    a_mc_only: assert property (p_mc_only) else $error("microcore path wrong");

    property p_flag_or;
        @(posedge i_clk) disable iff (!i_nrst)
            (!cfg.routing[4] && i_flags[cfg.routing[3:0]] && !ctrl[hsd_pkg::CTRL_FW_EN]) |=> hs_cmd;
    endproperty
    a_flag_or: assert property (p_flag_or) else $error("flag path not ored or inverted");

    property p_inv_diag;
        @(posedge i_clk) disable iff (!i_nrst) cfg.routing[4] |-> diag_cmd == i_mc_cmd;
    endproperty
    a_inv_diag: assert property (p_inv_diag) else $error("invert reached diagnostics");

    property p_gate;
        @(posedge i_clk) disable iff (!i_nrst) (!i_drv_en && !(cfg.enable_bypass && BYPASS_OK)) |-> !o_hs_drive;
    endproperty
    a_gate: assert property (p_gate) else $error("drive without enable");

    property p_lock;
        @(posedge i_clk) disable iff (!i_nrst) !BYPASS_OK |-> !cfg.enable_bypass;
    endproperty
    a_lock: assert property (p_lock) else $error("bypass set on locked channel");

    property p_snap;
        @(posedge i_clk) disable iff (!i_nrst) $rose(o_mc_error) |-> snap == {$past(diag_cmd_q), $past(src_filt),
                                                                           $past(vds_filt)};
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not latched");

    property p_filtered;
        @(posedge i_clk) disable iff (!i_nrst) err_vds |-> $past(cfg.tbl_vds[{diag_cmd_q, vds_filt}]);
    endproperty
    a_filtered: assert property (p_filtered) else $error("raw feedback used");

    // main scenarios
    c_vds_err: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(err_vds));
    c_src_err: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(err_src));
    c_fw: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(fw_cmd));
    c_irq: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_irq));
endmodule

//--- tb/hsd_mc_model.sv
// microcore stand-in: issues the channel command and the diagnostics enable
// assumes the bench changes its requests just after a rising edge
`timescale 1ns/1ps
module hsd_mc_model (
    input wire logic i_clk, // system clock
    input wire logic i_nrst, // async reset, low
    input wire logic i_want_cmd, // command asked by bench
    input wire logic i_want_diag, // diagnostics asked by bench
    output logic o_mc_cmd, // command to channel
    output logic o_mc_diag_en // diagnostics enable
);
    // register requests; diagnostics only on explicit request
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mc_cmd <= 1'b0;
            o_mc_diag_en <= 1'b0;
        end else begin
            o_mc_cmd <= i_want_cmd;
            o_mc_diag_en <= i_want_diag;
        end
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for one high-side channel built as channel five
// assumes the channel answers every bus request well inside the watchdog span
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic want_cmd = 1'b0;
    logic want_diag = 1'b0;
    logic [15:0] flags = 16'h0000;
    logic drv_en = 1'b1;
    logic fb_d = 1'b0;
    logic fb_s = 1'b0;
    logic [31:0] rdata, rv;
    logic wait_req, mc_cmd, diag_en, hs, fw, mc_err, irq;
    logic [2:0] snap;
    logic [4:0] obs;
    logic [15:0] fcfg [4] = '{16'h0183, 16'h0183, 16'h0183, 16'h2183};
    logic [7:0] pat [4] = '{8'h07, 8'h0F, 8'h77, 8'h77};
    logic [3:0] fexp = 4'hA;
    int errors = 0;
    int checks_done = 0;
    int n;
    assign obs = {irq, mc_err, fw, hs, mc_cmd};
    // 125 MHz clock
    always #4 i_clk = ~i_clk;
    hsd_mc_model hsd_mc_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_want_cmd(want_cmd),
        .i_want_diag(want_diag), .o_mc_cmd(mc_cmd), .o_mc_diag_en(diag_en));
    hsd_channel #(.CHANNEL(5)) hsd_channel_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_mc_cmd(mc_cmd), .i_mc_diag_en(diag_en),
        .i_flags(flags), .i_drv_en(drv_en), .i_hs_drain_feedback(fb_d), .i_hs_source_feedback(fb_s),
        .o_hs_drive(hs), .o_freewheel_command(fw), .o_mc_error(mc_err), .o_err_snapshot(snap), .o_irq(irq));
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one transfer held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic is_rd, input logic [9:0] idx, input logic [15:0] d);
        @(posedge i_clk);
        addr <= {idx, 2'b00};
        rd <= is_rd;
        wr <= !is_rd;
        wdata <= {16'h0000, d};
        do @(posedge i_clk); while (wait_req !== 1'b0);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
        bus(1'b1, idx, 16'h0000);
        chk("register", rv, e);
    endtask
    // count negedges until an observed output reaches a level
    task automatic wait_for(input int i, input logic v);
        n = 0;
        while (obs[i] !== v && n < 300) begin
            @(negedge i_clk);
            n++;
        end
    endtask
    task automatic set_cmd(input logic v);
        @(posedge i_clk);
        want_cmd <= v;
        wait_for(0, v);
    endtask
    task automatic out_case(input logic [15:0] rt, input logic [15:0] fl, input logic c, input logic de, input logic e);
        bus(1'b0, hsd_pkg::IDX_ROUTING_CFG, rt);
        flags <= fl;
        want_cmd <= c;
        drv_en <= de;
        repeat (4) @(negedge i_clk);
        chk("hs_drive", {31'h0, hs}, {31'h0, e});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd_chk(hsd_pkg::IDX_FILTER_CFG, 32'h0);
        rd_chk(hsd_pkg::IDX_ROUTING_CFG, 32'h3E);
        rd_chk(10'h3FF, 32'h0);
        bus(1'b0, hsd_pkg::IDX_TABLE_CFG, 16'hFFFF);
        rd_chk(hsd_pkg::IDX_TABLE_CFG, 32'hFF);
        out_case(16'h003E, 16'hFFFF, 1'b1, 1'b1, 1'b1);
        out_case(16'h003E, 16'hFFFF, 1'b0, 1'b1, 1'b0);
        for (int r = 0; r < 16; r++) begin
            out_case({10'h0, r[4:0], 1'b0}, 16'h1 << r, 1'b0, 1'b1, 1'b1);
            out_case({10'h0, r[4:0], 1'b0}, ~(16'h1 << r), 1'b0, 1'b1, 1'b0);
        end
        out_case(16'h003F, 16'h0, 1'b0, 1'b1, 1'b1);
        out_case(16'h0005, 16'h4, 1'b1, 1'b1, 1'b1);
        out_case(16'h0005, 16'h0, 1'b1, 1'b1, 1'b0);
        out_case(16'h803E, 16'h0, 1'b1, 1'b0, 1'b1);
        rd_chk(hsd_pkg::IDX_ROUTING_CFG, 32'h803E);
        out_case(16'h003E, 16'h0, 1'b1, 1'b0, 1'b0);
        // freewheel mode with dead time five
        bus(1'b0, hsd_pkg::IDX_CTRL, 16'h0001);
        out_case(16'h017E, 16'h0, 1'b1, 1'b1, 1'b1);
        set_cmd(1'b0);
        wait_for(1, 1'b0);
        chk("hs_fall", n, 1);
        wait_for(2, 1'b1);
        chk("fw_delay", n, 6);
        set_cmd(1'b1);
        wait_for(2, 1'b0);
        chk("fw_fall", n, 1);
        wait_for(1, 1'b1);
        chk("hs_delay", n, 6);
        // diagnostics, inverted output, window three
        bus(1'b0, hsd_pkg::IDX_CTRL, 16'h0000);
        bus(1'b0, hsd_pkg::IDX_ROUTING_CFG, 16'h003F);
        bus(1'b0, hsd_pkg::IDX_FILTER_CFG, 16'h0003);
        bus(1'b0, hsd_pkg::IDX_TABLE_CFG, 16'h0084);
        fb_s <= 1'b1;
        set_cmd(1'b0);
        set_cmd(1'b1);
        repeat (20) @(negedge i_clk);
        chk("err_no_diag", {31'h0, mc_err}, 32'h0);
        set_cmd(1'b0);
        want_diag <= 1'b1;
        repeat (20) @(negedge i_clk);
        set_cmd(1'b1);
        wait_for(3, 1'b1);
        chk("blank_span", {31'h0, n >= 7 && n <= 11}, 32'h1);
        chk("hs_inverted", {31'h0, hs}, 32'h0);
        chk("snapshot", {29'h0, snap}, 32'h6);
        rd_chk(hsd_pkg::IDX_IRQ_STATUS, 32'h3);
        rd_chk(hsd_pkg::IDX_STATE, 32'h2E);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        bus(1'b0, hsd_pkg::IDX_IRQ_MASK, 16'h0003);
        fb_d <= 1'b1;
        fb_s <= 1'b0;
        repeat (4) @(negedge i_clk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        bus(1'b0, hsd_pkg::IDX_IRQ_STATUS, 16'h0003);
        rd_chk(hsd_pkg::IDX_IRQ_STATUS, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        // filter span and kind, judged through off/high errors
        set_cmd(1'b0);
        @(posedge i_clk);
        fb_d <= 1'b0;
        repeat (10) @(negedge i_clk);
        bus(1'b0, hsd_pkg::IDX_TABLE_CFG, 16'h0002);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, hsd_pkg::IDX_FILTER_CFG, fcfg[i]);
            for (int b = 0; b < 8; b++) begin
                @(posedge i_clk);
                fb_d <= pat[i][b];
            end
            repeat (12) @(negedge i_clk);
            rd_chk(hsd_pkg::IDX_IRQ_STATUS, {31'h0, fexp[i]});
            bus(1'b0, hsd_pkg::IDX_IRQ_STATUS, 16'h0003);
        end
        tally_and_finish();
    end
endmodule
